// File: hdl/fws_ctrl.sv
// apb-driven controller that programs and erases an asynchronous flash
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// - Aborted byte is unknown; software repeats program or erases block.
// - Erase writes 20H then D0H, both at the block address.
// - Dropping reset pin or supply during erase aborts; software repeats.
// - Supply-low seen blocks program and erase until status is cleared.
// - Read array writes FFH to return the flash to array mode.
// - Supply stays high through program and erase or the sequence aborts.
// - Software clears status after an error before retrying.
// - Status check may follow each erase or a series of erases.
// - Program writes 40H then the address and data byte.
module fws_ctrl (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // flash pins
  output logic      [19:0] flash_addr_out,
  output logic      [7:0]  flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [7:0]  flash_dq_in,
  output logic             flash_ce_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out,
  output logic             powerdown_reset_input_n_out,
  output logic             programming_supply_high_en_out,
  input  wire logic        ready_busy_output_in
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  fws_pkg::fws_state_t st_reg, st_next;
  fws_pkg::fws_act_t   act;
  logic [2:0]  op_reg, op_next;
  logic [1:0]  step_reg, step_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [19:0] addr_reg, addr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic [1:0]  cfg_reg, cfg_next;
  logic [7:0]  stat_reg, stat_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        abort_reg, abort_next;
  logic        refused_reg, refused_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;
  logic        ce_n_reg, ce_n_next, oe_n_reg, oe_n_next;
  logic        we_n_reg, we_n_next, dq_oe_reg, dq_oe_next;
  logic [7:0]  dq_reg, dq_next;
  logic [7:0]  dq_s1_reg, dq_s2_reg;
  logic        rb_s1_reg, rb_s2_reg;
  logic [7:0]  act_byte;
  logic        act_last, wr_acc, start, start_ok, hv_op, suspended, advance;
  logic        susp_take;
  logic [31:0] status_word;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // two stages on ready/busy and the data bus
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      rb_s1_reg <= ready_busy_output_in;
      rb_s2_reg <= rb_s1_reg;
      dq_s1_reg <= flash_dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // step decode: what each op does at each step
  // ------------------------------------------------------------
  always_comb begin
    act      = fws_pkg::act_rd;
    act_byte = 8'h00;
    act_last = 1'b0;
    case (op_reg)
      fws_pkg::OP_PROG, fws_pkg::OP_ERASE: begin
        if (step_reg == 2'd0) begin
          act      = fws_pkg::act_wr;
          act_byte = (op_reg == fws_pkg::OP_PROG) ?
                     fws_pkg::CMD_PROG_SETUP : fws_pkg::CMD_ERASE_SETUP;
        end else if (step_reg == 2'd1) begin
          act      = fws_pkg::act_wr;
          act_byte = (op_reg == fws_pkg::OP_PROG) ?
                     wdata_reg : fws_pkg::CMD_CONFIRM;
        end else if (step_reg == 2'd2) begin
          act = fws_pkg::act_wait;
        end else begin
          act_last = 1'b1; // status read closes the sequence
        end
      end
      fws_pkg::OP_SUSP, fws_pkg::OP_RESUME: begin
        if (step_reg == 2'd0) begin
          act      = fws_pkg::act_wr;
          act_byte = (op_reg == fws_pkg::OP_SUSP) ?
                     fws_pkg::CMD_SUSPEND : fws_pkg::CMD_CONFIRM;
        end else if (step_reg == 2'd1) begin
          act = fws_pkg::act_wait;
        end else begin
          act_last = 1'b1;
        end
      end
      fws_pkg::OP_CLEAR: begin
        act      = fws_pkg::act_wr;
        act_byte = fws_pkg::CMD_CLEAR_STAT;
        act_last = 1'b1;
      end
      default: begin
        if (step_reg == 2'd0) begin
          act      = fws_pkg::act_wr;
          act_byte = (op_reg == fws_pkg::OP_RDARR) ?
                     fws_pkg::CMD_READ_ARRAY : fws_pkg::CMD_READ_STAT;
        end else begin
          act_last = 1'b1;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // start acceptance
  // ------------------------------------------------------------
  assign wr_acc    = psel_in & penable_in & pwrite_in;
  assign start     = wr_acc && paddr_in == fws_pkg::CTRL_OFS &&
                     pwdata_in[2:0] != fws_pkg::OP_NONE;
  assign hv_op     = pwdata_in[2:0] == fws_pkg::OP_PROG ||
                     pwdata_in[2:0] == fws_pkg::OP_ERASE;
  assign suspended = stat_reg[fws_pkg::SEQ_READY_BIT] &
                     stat_reg[fws_pkg::ERASE_SUSP_BIT];
  assign start_ok  = st_reg == fws_pkg::st_idle &&
                     cfg_reg[fws_pkg::CFG_RP_BIT] &&
                     !(hv_op && (stat_reg[fws_pkg::SUPPLY_LOW_BIT] ||
                                 !cfg_reg[fws_pkg::CFG_VPP_BIT])) &&
                     !(suspended &&
                       pwdata_in[2:0] != fws_pkg::OP_RDARR &&
                       pwdata_in[2:0] != fws_pkg::OP_RDSTAT &&
                       pwdata_in[2:0] != fws_pkg::OP_RESUME);
  // suspend is the one op taken while busy: it breaks into an erase wait
  assign susp_take = start && st_reg == fws_pkg::st_wait &&
                     op_reg == fws_pkg::OP_ERASE &&
                     pwdata_in[2:0] == fws_pkg::OP_SUSP;

  // ------------------------------------------------------------
  // sequencer and register next values
  // ------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    op_next      = op_reg;
    step_next    = step_reg;
    cnt_next     = cnt_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    cfg_next     = cfg_reg;
    stat_next    = stat_reg;
    rdata_next   = rdata_reg;
    abort_next   = abort_reg;
    refused_next = refused_reg;
    advance      = 1'b0;
    // software writes; sticky flags are write-one-to-clear
    if (wr_acc) begin
      if (paddr_in == fws_pkg::ADDR_OFS && st_reg == fws_pkg::st_idle) begin
        addr_next = pwdata_in[19:0];
      end else if (paddr_in == fws_pkg::WDATA_OFS &&
                   st_reg == fws_pkg::st_idle) begin
        wdata_next = pwdata_in[7:0];
      end else if (paddr_in == fws_pkg::CONFIG_OFS) begin
        cfg_next = pwdata_in[1:0];
      end else if (paddr_in == fws_pkg::STATUS_OFS) begin
        if (pwdata_in[fws_pkg::ST_ABORT_BIT])   abort_next   = 1'b0;
        if (pwdata_in[fws_pkg::ST_REFUSED_BIT]) refused_next = 1'b0;
      end
    end
    case (st_reg)
      fws_pkg::st_idle: begin
        if (start && start_ok) begin
          op_next   = pwdata_in[2:0];
          step_next = 2'd0;
          st_next   = fws_pkg::st_step;
        end else if (start) begin
          refused_next = 1'b1;
        end
      end
      fws_pkg::st_step: begin
        if (act == fws_pkg::act_wr) begin
          st_next = fws_pkg::st_setup;
        end else if (act == fws_pkg::act_rd) begin
          st_next  = fws_pkg::st_read;
          cnt_next = fws_pkg::RD_CYC;
        end else begin
          st_next  = fws_pkg::st_wait;
          cnt_next = fws_pkg::BUSY_CYC;
        end
      end
      fws_pkg::st_setup: begin
        st_next  = fws_pkg::st_we;
        cnt_next = fws_pkg::WE_CYC;
      end
      fws_pkg::st_we: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) st_next = fws_pkg::st_hold;
      end
      fws_pkg::st_hold: begin
        advance = 1'b1; // flash latches on the rising strobe
      end
      fws_pkg::st_read: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          advance = 1'b1;
          if (op_reg == fws_pkg::OP_RDARR) rdata_next = dq_s2_reg;
          else stat_next = dq_s2_reg;
        end
      end
      default: begin
        if (susp_take) begin
          op_next   = fws_pkg::OP_SUSP;
          step_next = 2'd0;
          st_next   = fws_pkg::st_step;
        end else if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
        else if (rb_s2_reg) advance = 1'b1;
      end
    endcase
    // any other start while busy is refused and flagged
    if (start && st_reg != fws_pkg::st_idle && !susp_take) begin
      refused_next = 1'b1;
    end
    if (advance) begin
      if (act_last) begin
        st_next = fws_pkg::st_idle;
        if (op_reg == fws_pkg::OP_CLEAR) begin
          stat_next[5:3] = 3'b000;
        end
      end else begin
        step_next = step_reg + 2'd1;
        st_next   = fws_pkg::st_step;
      end
    end
    // reset pin low, or supply off under program/erase, kills the sequence
    if (st_reg != fws_pkg::st_idle &&
        (!cfg_reg[fws_pkg::CFG_RP_BIT] ||
         ((op_reg == fws_pkg::OP_PROG || op_reg == fws_pkg::OP_ERASE) &&
          !cfg_reg[fws_pkg::CFG_VPP_BIT]))) begin
      st_next    = fws_pkg::st_idle;
      abort_next = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // pin drive next values, from the next state
  // ------------------------------------------------------------
  always_comb begin
    ce_n_next  = !(st_next == fws_pkg::st_setup ||
                   st_next == fws_pkg::st_we ||
                   st_next == fws_pkg::st_hold ||
                   st_next == fws_pkg::st_read);
    we_n_next  = st_next != fws_pkg::st_we;
    oe_n_next  = st_next != fws_pkg::st_read;
    dq_oe_next = st_next == fws_pkg::st_setup ||
                 st_next == fws_pkg::st_we ||
                 st_next == fws_pkg::st_hold;
    dq_next    = dq_oe_next ? act_byte : dq_reg;
  end

  // ------------------------------------------------------------
  // apb read data and error, captured in the setup cycle
  // ------------------------------------------------------------
  assign status_word = {19'h0, refused_reg, abort_reg, suspended,
                        rb_s2_reg, st_reg != fws_pkg::st_idle, stat_reg};
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel_in && !penable_in) begin
      pslverr_next = 1'b0;
      prdata_next  = 32'h0;
      if (paddr_in == fws_pkg::CTRL_OFS) begin
        prdata_next = {29'h0, op_reg};
      end else if (paddr_in == fws_pkg::ADDR_OFS) begin
        prdata_next = {12'h0, addr_reg};
      end else if (paddr_in == fws_pkg::WDATA_OFS) begin
        prdata_next = {24'h0, wdata_reg};
      end else if (paddr_in == fws_pkg::CONFIG_OFS) begin
        prdata_next = {30'h0, cfg_reg};
      end else if (paddr_in == fws_pkg::STATUS_OFS) begin
        prdata_next = status_word;
      end else if (paddr_in == fws_pkg::RDATA_OFS) begin
        prdata_next = {24'h0, rdata_reg};
      end else begin
        pslverr_next = 1'b1; // unmapped address
      end
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg      <= fws_pkg::st_idle;
      op_reg      <= fws_pkg::OP_NONE;
      step_reg    <= 2'd0;
      cnt_reg     <= 8'h00;
      addr_reg    <= 20'h00000;
      wdata_reg   <= 8'hff;
      cfg_reg     <= 2'b00;
      stat_reg    <= fws_pkg::STAT_RESET;
      rdata_reg   <= 8'h00;
      abort_reg   <= 1'b0;
      refused_reg <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
      ce_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      dq_oe_reg   <= 1'b0;
      dq_reg      <= 8'h00;
    end else begin
      st_reg      <= st_next;
      op_reg      <= op_next;
      step_reg    <= step_next;
      cnt_reg     <= cnt_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      cfg_reg     <= cfg_next;
      stat_reg    <= stat_next;
      rdata_reg   <= rdata_next;
      abort_reg   <= abort_next;
      refused_reg <= refused_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      ce_n_reg    <= ce_n_next;
      oe_n_reg    <= oe_n_next;
      we_n_reg    <= we_n_next;
      dq_oe_reg   <= dq_oe_next;
      dq_reg      <= dq_next;
    end
  end

  // outputs
  assign prdata_out  = prdata_reg;
  assign pready_out  = psel_in & penable_in; // zero wait states
  assign pslverr_out = psel_in & penable_in & pslverr_reg;
  assign flash_addr_out  = addr_reg;
  assign flash_dq_out    = dq_reg;
  assign flash_dq_oe_out = dq_oe_reg;
  assign flash_ce_n_out  = ce_n_reg;
  assign flash_oe_n_out  = oe_n_reg;
  assign flash_we_n_out  = we_n_reg;
  assign powerdown_reset_input_n_out    = cfg_reg[fws_pkg::CFG_RP_BIT];
  assign programming_supply_high_en_out = cfg_reg[fws_pkg::CFG_VPP_BIT];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  abort_on_rp_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_reg != fws_pkg::st_idle && !powerdown_reset_input_n_out)
    |=> st_reg == fws_pkg::st_idle && abort_reg)
    else $error("sequence not aborted on reset pin low");
  supply_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_reg != fws_pkg::st_idle && !programming_supply_high_en_out &&
     (op_reg == fws_pkg::OP_PROG || op_reg == fws_pkg::OP_ERASE))
    |=> st_reg == fws_pkg::st_idle)
    else $error("program or erase kept running without supply");
  erase_confirm_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!flash_we_n_out && op_reg == fws_pkg::OP_ERASE)
    |-> flash_dq_oe_out && !flash_ce_n_out &&
        flash_dq_out == (step_reg == 2'd0 ? 8'h20 : 8'hd0))
    else $error("wrong erase command byte");
  prog_setup_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!flash_we_n_out && op_reg == fws_pkg::OP_PROG && step_reg == 2'd0)
    |-> flash_dq_out == 8'h40)
    else $error("wrong program setup byte");
  read_array_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (op_reg == fws_pkg::OP_RDARR && st_reg == fws_pkg::st_hold)
    |-> $past(flash_dq_out, 2) == 8'hff && flash_oe_n_out)
    else $error("read array did not write ffh");
  busy_poll_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_reg == fws_pkg::st_wait && (!rb_s2_reg || cnt_reg != 8'h00) &&
     !susp_take)
    |=> st_reg == fws_pkg::st_wait || st_reg == fws_pkg::st_idle)
    else $error("wait left before delay and ready");
  supply_low_block_a: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (start && hv_op && stat_reg[fws_pkg::SUPPLY_LOW_BIT] &&
     st_reg == fws_pkg::st_idle)
    |=> st_reg == fws_pkg::st_idle && refused_reg)
    else $error("program or erase started with supply low latched");
  suspend_only_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (start && suspended && pwdata_in[2:0] == fws_pkg::OP_PROG)
    |=> st_reg == fws_pkg::st_idle ##1 st_reg == fws_pkg::st_idle)
    else $error("program started while erase suspended");
  clear_status_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (op_reg == fws_pkg::OP_CLEAR && st_reg == fws_pkg::st_hold &&
     cfg_reg[fws_pkg::CFG_RP_BIT])
    |=> stat_reg[5:3] == 3'b000)
    else $error("clear status left error bits set");
  suspend_take_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (susp_take && cfg_reg[fws_pkg::CFG_RP_BIT] &&
     cfg_reg[fws_pkg::CFG_VPP_BIT])
    |=> op_reg == fws_pkg::OP_SUSP && st_reg == fws_pkg::st_step)
    else $error("suspend not taken during erase wait");

endmodule // fws_ctrl

// File: pkg/fws_pkg.sv
// constants shared by the flash write/erase sequencer controller
package fws_pkg;

  // ------------------------------------------------------------
  // register offsets on the apb side
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00; // op start, reads last op
  localparam logic [7:0] ADDR_OFS   = 8'h04; // flash byte address
  localparam logic [7:0] WDATA_OFS  = 8'h08; // byte to program
  localparam logic [7:0] CONFIG_OFS = 8'h0c; // pin levels held by software
  localparam logic [7:0] STATUS_OFS = 8'h10; // state and sticky flags
  localparam logic [7:0] RDATA_OFS  = 8'h14; // last array byte read

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_RP_BIT      = 0;  // powerdown/reset pin released
  localparam int CFG_VPP_BIT     = 1;  // programming supply switched high
  localparam int ST_BUSY_BIT     = 8;  // controller sequence running
  localparam int ST_RB_BIT       = 9;  // synchronised ready/busy pin
  localparam int ST_SUSP_BIT     = 10; // erase suspended
  localparam int ST_ABORT_BIT    = 11; // sticky: sequence aborted
  localparam int ST_REFUSED_BIT  = 12; // sticky: start refused
  localparam int SEQ_READY_BIT   = 7;  // sequencer_ready_bit
  localparam int ERASE_SUSP_BIT  = 6;  // erase_suspended_bit
  localparam int ERASE_ERR_BIT   = 5;  // erase_error_bit
  localparam int PROG_ERR_BIT    = 4;  // program_error_bit
  localparam int SUPPLY_LOW_BIT  = 3;  // supply_low_bit

  // ------------------------------------------------------------
  // operations written to ctrl[2:0]
  // ------------------------------------------------------------
  localparam logic [2:0] OP_NONE   = 3'h0;
  localparam logic [2:0] OP_PROG   = 3'h1;
  localparam logic [2:0] OP_ERASE  = 3'h2;
  localparam logic [2:0] OP_SUSP   = 3'h3;
  localparam logic [2:0] OP_RESUME = 3'h4;
  localparam logic [2:0] OP_CLEAR  = 3'h5;
  localparam logic [2:0] OP_RDARR  = 3'h6;
  localparam logic [2:0] OP_RDSTAT = 3'h7;

  // ------------------------------------------------------------
  // flash command bytes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_READ_STAT   = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [7:0] STAT_RESET = 8'h80; // sequencer ready, no errors
  localparam int CLK_NS              = 50;
  localparam int WE_PULSE_NS         = 100; // write strobe low time
  localparam int RD_ACCESS_NS        = 150; // strobe to valid data
  localparam int WRITE_TO_BUSY_DELAY_NS = 250; // write_to_busy_delay
  localparam int SYNC_STAGES         = 2;
  localparam logic [7:0] WE_CYC =
    8'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RD_CYC =
    8'((RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [7:0] BUSY_CYC =
    8'((WRITE_TO_BUSY_DELAY_NS + CLK_NS - 1) / CLK_NS);

  // ------------------------------------------------------------
  // step actions and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {act_wr, act_rd, act_wait} fws_act_t;
  typedef enum {st_idle, st_step, st_setup, st_we, st_hold, st_read,
                st_wait} fws_state_t;

endpackage

// File: verif/fws_flash_model.sv
// behavioural model of the flash device on the far side of the controller
`timescale 1ns/1ps
module fws_flash_model #(
  parameter int PROG_CYC  = 40,
  parameter int ERASE_CYC = 200
) (
  // time base and error injection
  input  wire logic        clk_in,
  input  wire logic        efail_in,
  // flash pins
  input  wire logic [19:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        rp_n_in,
  input  wire logic        vpp_in,
  output logic      [7:0]  dq_out,
  output logic             rb_out
);
  logic [7:0]  sr = 8'h80, mem = 8'hff, last = 8'h00;
  logic [19:0] maddr = 20'h00000;
  logic [1:0]  setup = 2'h0;
  logic        stat = 1'b0, susp = 1'b0, we_q = 1'b1, ers = 1'b0;
  int          cnt = 0;
  // ready/busy always driven, high in powerdown or suspend
  assign rb_out = !rp_n_in || susp || cnt == 0;
  // released bus shows the inverse of the last value
  assign dq_out = (!ce_n_in && !oe_n_in) ?
    (stat ? sr : (addr_in == maddr ? mem : 8'hff)) : ~last;
  // command decode on the rising write strobe, sequencer countdown
  always @(posedge clk_in) begin
    we_q <= we_n_in;
    if (!ce_n_in && !oe_n_in) last <= dq_out;
    if (!rp_n_in) begin
      sr <= 8'h80; stat <= 1'b0; setup <= 2'h0; susp <= 1'b0; cnt <= 0;
    end else if (cnt > 1 && !susp) begin
      cnt <= vpp_in ? cnt - 1 : 0;
      if (!vpp_in) sr <= 8'h88;
    end else if (cnt == 1) begin
      cnt <= 0;
      sr[7] <= 1'b1;
      if (ers) mem <= 8'hff;
      if (ers && efail_in) sr[5] <= 1'b1;
    end
    if (rp_n_in && we_n_in && !we_q && !ce_n_in) begin
      setup <= 2'h0;
      if (setup != 2'h0) begin
        stat <= 1'b1;
        if (setup == 2'h2 && dq_in != 8'hd0) sr <= sr | 8'h30;
        else if (sr[3] || !vpp_in) sr <= sr | 8'h08;
        else begin
          sr[7] <= 1'b0;
          ers <= setup == 2'h2;
          cnt <= setup == 2'h2 ? ERASE_CYC : PROG_CYC;
          if (setup == 2'h1) mem <= dq_in;
          if (setup == 2'h1) maddr <= addr_in;
        end
      end else if (!susp || dq_in inside {8'hff, 8'h70, 8'hd0}) begin
        case (dq_in)
          8'h40: setup <= 2'h1;
          8'h20: setup <= 2'h2;
          8'hb0: if (cnt > 0) begin susp <= 1'b1; sr[7:6] <= 2'h3; end
          8'hd0: if (susp) begin susp <= 1'b0; sr[7:6] <= 2'h0; end
          8'h50: sr[5:3] <= 3'h0;
          8'h70: stat <= 1'b1;
          8'hff: stat <= 1'b0;
          default: ;
        endcase
      end
    end
  end
endmodule // fws_flash_model

// File: verif/tb_top.sv
// testbench: apb register tests of the flash controller
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] CT = fws_pkg::CTRL_OFS, ST = fws_pkg::STATUS_OFS;
  logic mclk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [7:0] paddr_in = 0, flash_dq_out, fm_dq, flash_dq_in;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic pready_out, pslverr_out, flash_dq_oe_out, flash_ce_n_out, err;
  logic flash_oe_n_out, flash_we_n_out, powerdown_reset_input_n_out;
  logic programming_supply_high_en_out, ready_busy_output_in, efail = 0;
  logic [19:0] flash_addr_out;
  int fail_count = 0, compares = 0, cyc = 0;
  // resolved data bus level
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : fm_dq;
  fws_ctrl uut (.mclk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_dq_in,
    .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out,
    .powerdown_reset_input_n_out, .programming_supply_high_en_out,
    .ready_busy_output_in);
  fws_flash_model fm (.clk_in(mclk_in), .efail_in(efail),
    .addr_in(flash_addr_out), .dq_in(flash_dq_in),
    .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .rp_n_in(powerdown_reset_input_n_out),
    .vpp_in(programming_supply_high_en_out), .dq_out(fm_dq),
    .rb_out(ready_busy_output_in));
  // clock and hang limit
  initial forever #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin fail_count++; report_and_stop; end
  end
  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0; penable_in <= 0;
    @(posedge mclk_in); // idle cycle keeps psel from toggling in one step
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++; $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // poll status until the controller is idle
  task automatic idle;
    do xfer(0, ST, 0); while (rd[8] !== 1'b0);
  endtask
  task automatic op(input logic [2:0] o);
    xfer(1, CT, {29'h0, o}); idle;
  endtask
  task report_and_stop;
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // test sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 0;
    @(posedge mclk_in);
    xfer(0, ST, 0); chk("st_rst", rd & 32'h1ff, 32'h080);
    xfer(1, CT, 1); xfer(0, ST, 0); chk("refuse", {31'h0, rd[12]}, 1);
    xfer(0, 8'h18, 0); chk("unmap", {err, rd[30:0]}, 32'h80000000);
    xfer(1, ST, 32'h1800); xfer(1, 8'h0c, 1); xfer(1, CT, 1);
    xfer(0, ST, 0); chk("vpp_off", {31'h0, rd[12]}, 1);
    xfer(1, ST, 32'h1800); xfer(1, 8'h0c, 3); xfer(1, 8'h04, 32'h12345);
    xfer(1, 8'h08, 32'h5a); op(1);
    chk("prog", rd & 32'h1fff, 32'h280);
    chk("cell", {24'h0, fm.mem}, 32'h5a);
    op(6); xfer(0, 8'h14, 0); chk("rdarr", rd, 32'h5a);
    efail <= 1; xfer(1, CT, 2);
    do xfer(0, ST, 0); while (rd[9] !== 1'b0);
    xfer(1, CT, 6); xfer(0, ST, 0);
    chk("busy_ref", {31'h0, rd[12]}, 1);
    xfer(1, CT, 3); idle; chk("susp", rd & 32'h7ff, 32'h6c0);
    xfer(1, ST, 32'h1000); xfer(1, CT, 1); xfer(0, ST, 0);
    chk("susp_ref", {31'h0, rd[12]}, 1);
    op(4); efail <= 0; chk("eerr", rd & 32'hff, 32'ha0);
    op(2); chk("eacc", rd & 32'hff, 32'ha0);
    op(5); chk("clr", rd & 32'h138, 32'h0);
    op(6); xfer(0, 8'h14, 0); chk("erased", rd, 32'hff);
    for (int i = 1; i < 3; i++) begin
      xfer(1, 8'h0c, 3); xfer(1, ST, 32'h1800); xfer(1, CT, i);
      repeat (12) @(posedge mclk_in);
      xfer(1, 8'h0c, i == 1 ? 2 : 1); xfer(0, ST, 0);
      chk("abort", {rd[11:8], 3'h0, flash_ce_n_out}, 8'h81);
    end
    xfer(1, 8'h0c, 3); op(7); chk("slow", rd & 32'hff, 32'h88);
    xfer(1, CT, 2); xfer(0, ST, 0);
    chk("slow_ref", {31'h0, rd[12]}, 1);
    report_and_stop;
  end
endmodule // tb_top
